/* core/adcs_sequencer.sv */
// conversion sequencer with apb registers, sar control and interrupt
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"
// How it works
// RQ1: result byte pair has no reset value; power-on leaves it unknown.
// RQ2: software makes analog channel pins inputs before converting.
// RQ3: software waits the acquisition time after choosing a channel.
// RQ4: software sets go/done, then polls it or waits for interrupt.
// RQ5: software clears flag, then enables interrupts, then starts.
// RQ6: two clock periods pass after completion before acquisition resumes.
// RQ7: each conversion takes exactly twelve conversion-clock periods.
// RQ8: three-bit select picks divide by 2..64 or the private rc clock.
// RQ9: software picks a conversion clock period of at least 1.6 us.
// RQ10: an output-driven analog pin converts its driven level.
// RQ11: port reads show zero on every analog-configured pin.
// RQ12: a digital-input pin still converts when it is selected.
// RQ13: clearing go/done mid-conversion aborts it at once.
// RQ14: an abort leaves the result byte pair untouched.
// RQ15: after abort wait two periods, then acquire automatically; code waits two divider ticks, between one and two periods.
// RQ16: go/done written with the enabling write is ignored.
// RQ17: completion loads result, clears go/done, sets complete flag.
// RQ18: any reset turns converter off and aborts conversion.
// RQ19: the clock divider restarts at every conversion start.
module adcs_sequencer import adcs_pkg::*; #(
  parameter int RC_DIV = `ADCS_RC_DIV,
  parameter int CHANNELS = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`ADCS_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [CHANNELS-1:0] i_pin_level,
  input wire logic i_cmp_hi,
  output logic [3:0] o_chan_sel,
  output logic o_sample,
  output logic [9:0] o_sar_code,
  output logic [1:0] o_vref_cfg,
  output logic o_irq
);
  initial begin
    if (CHANNELS != 16) $error("CHANNELS must be 16");
  end

  adcs_ctrl_type ctrl_q;
  adcs_pcfg_type pcfg_q;
  adcs_clkf_type clkf_q;
  adcs_state_type state_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [31:0] rdata_q;
  logic [3:0] tad_cnt_q;
  logic [1:0] wait_cnt_q;
  logic [9:0] sar_q;
  logic tick;
  logic start;
  logic done;
  logic abort;
  logic wr;
  logic rd_end;
  logic mapped;
  logic [CHANNELS-1:0] analog_map;
  logic [9:0] result;

  // analog channels for a port configuration code
  function automatic logic [15:0] analog_of(input logic [3:0] cfg);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (cfg == 4'h0) begin
        m[i] = 1'b1;
      end else if (cfg != `ADCS_PCFG_NONE &&
          5'(i) <= `ADCS_PCFG_TOP - {1'b0, cfg}) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // true when the address names a register
  function automatic logic is_mapped(input logic [`ADCS_AW-1:0] a);
    logic r;
    r = 1'b0;
    if (a == `ADCS_OFF_CTRL) r = 1'b1;
    else if (a == `ADCS_OFF_PCFG) r = 1'b1;
    else if (a == `ADCS_OFF_CLKF) r = 1'b1;
    else if (a == `ADCS_OFF_RESH) r = 1'b1;
    else if (a == `ADCS_OFF_RESL) r = 1'b1;
    else if (a == `ADCS_OFF_STAT) r = 1'b1;
    else if (a == `ADCS_OFF_MASK) r = 1'b1;
    else if (a == `ADCS_OFF_PORT) r = 1'b1;
    return r;
  endfunction

  // apb handshake: zero wait states, error on unmapped addresses
  assign mapped = is_mapped(i_paddr);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign wr = i_psel && i_penable && i_pwrite && mapped;
  assign rd_end = i_psel && i_penable && !i_pwrite;
  assign o_prdata = rdata_q;
  assign analog_map = analog_of(pcfg_q.port_cfg);

  // sequencer events
  assign start = state_q == ADCS_IDLE && ctrl_q.converter_on
    && ctrl_q.go_done;
  assign done = state_q == ADCS_CONV && ctrl_q.go_done
    && ctrl_q.converter_on && tick && tad_cnt_q == `ADCS_LAST_TAD; // RQ7
  assign abort = state_q == ADCS_CONV
    && (!ctrl_q.go_done || !ctrl_q.converter_on); // RQ13
  assign result = sar_q;

  adcs_tad_gen #(
    .RC_DIV(RC_DIV)
  ) u_tad (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_restart(start),
    .i_sel(clkf_q.conv_clock_select),
    .o_tick(tick)
  );

  // read data captured in the setup phase
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      rdata_q <= 32'h0000_0000;
      if (i_paddr == `ADCS_OFF_CTRL) begin
        rdata_q[5:0] <= ctrl_q;
      end else if (i_paddr == `ADCS_OFF_PCFG) begin
        rdata_q[5:0] <= pcfg_q;
      end else if (i_paddr == `ADCS_OFF_CLKF) begin
        rdata_q[`ADCS_CLKF_JUST_BIT] <= clkf_q.right_just;
        rdata_q[2:0] <= clkf_q.conv_clock_select;
      end else if (i_paddr == `ADCS_OFF_RESH) begin
        rdata_q[7:0] <= res_hi_q;
      end else if (i_paddr == `ADCS_OFF_RESL) begin
        rdata_q[7:0] <= res_lo_q;
      end else if (i_paddr == `ADCS_OFF_STAT) begin
        rdata_q[1:0] <= stat_q;
      end else if (i_paddr == `ADCS_OFF_MASK) begin
        rdata_q[1:0] <= mask_q;
      end else if (i_paddr == `ADCS_OFF_PORT) begin
        rdata_q[15:0] <= i_pin_level & ~analog_map; // RQ11
      end
    end
  end

  // control register: enable, go/done and channel
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q <= `ADCS_CTRL_RST; // RQ18
    end else if (wr && i_paddr == `ADCS_OFF_CTRL) begin
      ctrl_q.channel_select <= i_pwdata[5:2];
      ctrl_q.converter_on <= i_pwdata[0];
      // go only counts once the converter is already on
      ctrl_q.go_done <= i_pwdata[1] && i_pwdata[0]
        && ctrl_q.converter_on; // RQ16
    end else if (done) begin
      ctrl_q.go_done <= 1'b0; // RQ17
    end
  end

  // port and clock configuration
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pcfg_q <= `ADCS_PCFG_RST;
      clkf_q <= `ADCS_CLKF_RST;
    end else if (wr && i_paddr == `ADCS_OFF_PCFG) begin
      pcfg_q <= i_pwdata[5:0];
    end else if (wr && i_paddr == `ADCS_OFF_CLKF) begin
      clkf_q.right_just <= i_pwdata[`ADCS_CLKF_JUST_BIT];
      clkf_q.conv_clock_select <= i_pwdata[2:0]; // RQ8
    end
  end

  // result pair: no reset, loaded only on completion or by software
  always_ff @(posedge i_clk) begin
    if (done) begin // RQ1
      if (clkf_q.right_just) begin
        res_hi_q <= {6'h00, result[9:8]}; // RQ17
        res_lo_q <= result[7:0];
      end else begin
        res_hi_q <= result[9:2];
        res_lo_q <= {result[1:0], 6'h00};
      end
    end else if (wr && i_paddr == `ADCS_OFF_RESH) begin
      res_hi_q <= i_pwdata[7:0]; // RQ14
    end else if (wr && i_paddr == `ADCS_OFF_RESL) begin
      res_lo_q <= i_pwdata[7:0];
    end
  end

  // sticky status, cleared by reading it; a new event wins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stat_q <= `ADCS_IRQ_RST;
    end else begin
      if (rd_end && i_paddr == `ADCS_OFF_STAT) begin
        stat_q <= `ADCS_IRQ_RST;
      end
      if (done) begin
        stat_q[`ADCS_ST_DONE] <= 1'b1; // RQ17
      end
      if (abort) begin
        stat_q[`ADCS_ST_ABORT] <= 1'b1;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask_q <= `ADCS_IRQ_RST;
    end else if (wr && i_paddr == `ADCS_OFF_MASK) begin
      mask_q <= i_pwdata[1:0];
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // conversion state machine
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ADCS_IDLE; // RQ18
    end else begin
      case (state_q)
        ADCS_IDLE: begin
          if (start) begin
            state_q <= ADCS_CONV;
          end
        end
        ADCS_CONV: begin
          if (abort || done) begin
            state_q <= ADCS_WAIT; // RQ15
          end
        end
        ADCS_WAIT: begin
          if (tick && wait_cnt_q == `ADCS_WAIT_TADS - 2'h1) begin
            state_q <= ADCS_IDLE; // RQ6
          end
        end
        default: state_q <= ADCS_IDLE;
      endcase
    end
  end

  // period counters for conversion and post-conversion wait
  always_ff @(posedge i_clk) begin
    if (i_srst || start) begin
      tad_cnt_q <= 4'h0;
      wait_cnt_q <= 2'h0;
    end else if (state_q == ADCS_CONV) begin
      wait_cnt_q <= 2'h0;
      if (tick) begin
        tad_cnt_q <= tad_cnt_q + 4'h1; // RQ7
      end
    end else if (state_q == ADCS_WAIT && tick) begin
      wait_cnt_q <= wait_cnt_q + 2'h1; // RQ15
    end
  end

  // successive approximation: one bit per period from the second to the eleventh
  always_ff @(posedge i_clk) begin
    if (i_srst || start) begin
      sar_q <= `ADCS_SAR_INIT;
    end else if (state_q == ADCS_CONV && tick
        && tad_cnt_q >= `ADCS_FIRST_BIT_TAD
        && tad_cnt_q <= `ADCS_LAST_BIT_TAD) begin
      if (!i_cmp_hi) begin
        sar_q[`ADCS_BIT_TOP - tad_cnt_q] <= 1'b0;
      end
      if (tad_cnt_q != `ADCS_LAST_BIT_TAD) begin
        sar_q[`ADCS_BIT_TOP - tad_cnt_q - 4'h1] <= 1'b1;
      end
    end
  end

  // analog front end: channel mux ignores pin direction and config
  assign o_chan_sel = ctrl_q.channel_select; // RQ10 RQ12
  assign o_sample = ctrl_q.converter_on && state_q == ADCS_IDLE; // RQ15
  assign o_sar_code = sar_q;
  assign o_vref_cfg = pcfg_q.vref_cfg;

  sequence s_abort_seen;
    state_q == ADCS_CONV && !ctrl_q.go_done;
  endsequence
  sequence s_wait_two;
    state_q == ADCS_WAIT && !o_sample;
  endsequence

  property p_abort_now;
    @(posedge i_clk) disable iff (i_srst)
      s_abort_seen |=> s_wait_two;
  endproperty
  a_abort_now: assert property (p_abort_now) else $error("abort late"); // RQ13

  property p_abort_keep;
    @(posedge i_clk) disable iff (i_srst)
      abort && !wr |=> $stable(res_hi_q) && $stable(res_lo_q);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("result hit"); // RQ14

  property p_done_effects;
    @(posedge i_clk) disable iff (i_srst)
      done && !wr |=> !ctrl_q.go_done && stat_q[`ADCS_ST_DONE]
        && state_q == ADCS_WAIT;
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("done"); // RQ17

  property p_twelve;
    @(posedge i_clk) disable iff (i_srst)
      done |-> tad_cnt_q == `ADCS_LAST_TAD && $past(state_q) == ADCS_CONV;
  endproperty
  a_twelve: assert property (p_twelve) else $error("not 12 periods"); // RQ7

  property p_no_acq_in_wait;
    @(posedge i_clk) disable iff (i_srst)
      state_q == ADCS_WAIT |-> !o_sample && wait_cnt_q < 2'h2;
  endproperty
  a_no_acq_in_wait: assert property (p_no_acq_in_wait)
    else $error("early acquisition"); // RQ6

  property p_auto_acq;
    @(posedge i_clk) disable iff (i_srst)
      state_q == ADCS_WAIT && tick && wait_cnt_q == 2'h1
        && ctrl_q.converter_on && !wr |=> o_sample;
  endproperty
  a_auto_acq: assert property (p_auto_acq) else $error("no reacquire"); // RQ15

  property p_reset_off;
    @(posedge i_clk) i_srst |=> !ctrl_q.converter_on
      && state_q == ADCS_IDLE && !o_sample;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset"); // RQ18

  property p_go_same_write;
    @(posedge i_clk) disable iff (i_srst)
      wr && i_paddr == `ADCS_OFF_CTRL && !ctrl_q.converter_on
      |=> !ctrl_q.go_done;
  endproperty
  a_go_same_write: assert property (p_go_same_write)
    else $error("go with enable"); // RQ16

  property p_port_zero;
    @(posedge i_clk) disable iff (i_srst)
      i_psel && !i_penable && !i_pwrite && i_paddr == `ADCS_OFF_PORT
      |=> (o_prdata[15:0] & analog_of($past(pcfg_q.port_cfg))) == 16'h0;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("analog pin"); // RQ11
endmodule // adcs_sequencer
`default_nettype wire

/* core/adcs_regs.svh */
// register offsets, field positions, reset values and counts of the sequencer
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
`define ADCS_AW 8
`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_PCFG 8'h04
`define ADCS_OFF_CLKF 8'h08
`define ADCS_OFF_RESH 8'h0c
`define ADCS_OFF_RESL 8'h10
`define ADCS_OFF_STAT 8'h14
`define ADCS_OFF_MASK 8'h18
`define ADCS_OFF_PORT 8'h1c
`define ADCS_CTRL_RST 6'h00
`define ADCS_PCFG_RST 6'h00
`define ADCS_CLKF_RST 4'h0
`define ADCS_IRQ_RST 2'h0
`define ADCS_CLKF_JUST_BIT 7
`define ADCS_ST_DONE 0
`define ADCS_ST_ABORT 1
`define ADCS_LAST_TAD 4'hb
`define ADCS_FIRST_BIT_TAD 4'h1
`define ADCS_LAST_BIT_TAD 4'ha
`define ADCS_BIT_TOP 4'ha
`define ADCS_WAIT_TADS 2'h2
`define ADCS_SAR_INIT 10'h200
`define ADCS_PCFG_NONE 4'hf
`define ADCS_PCFG_TOP 5'h0e
`define ADCS_DIV_2 7'h02
`define ADCS_DIV_4 7'h04
`define ADCS_DIV_8 7'h08
`define ADCS_DIV_16 7'h10
`define ADCS_DIV_32 7'h20
`define ADCS_DIV_64 7'h40
`define ADCS_RC_DIV 32
`endif

/* core/adcs_pkg.sv */
// types shared by the conversion sequencer files
package adcs_pkg;
  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b00,
    ADCS_CONV = 2'b01,
    ADCS_WAIT = 2'b10
  } adcs_state_type;
  typedef struct packed {
    logic [3:0] channel_select;
    logic go_done;
    logic converter_on;
  } adcs_ctrl_type;
  typedef struct packed {
    logic [1:0] vref_cfg;
    logic [3:0] port_cfg;
  } adcs_pcfg_type;
  typedef struct packed {
    logic right_just;
    logic [2:0] conv_clock_select;
  } adcs_clkf_type;
endpackage

/* core/adcs_tad_gen.sv */
// conversion-clock generator: divides the oscillator into period ticks
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"
module adcs_tad_gen import adcs_pkg::*; #(
  parameter int RC_DIV = `ADCS_RC_DIV
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_restart,
  input wire logic [2:0] i_sel,
  output logic o_tick
);
  initial begin
    if (RC_DIV < 2 || RC_DIV > 64) $error("RC_DIV must lie in 2..64");
  end

  // map the select code to a divide ratio
  function automatic logic [6:0] div_of(input logic [2:0] sel);
    logic [6:0] d;
    d = 7'(RC_DIV);
    case (sel)
      3'h0: d = `ADCS_DIV_2;
      3'h4: d = `ADCS_DIV_4;
      3'h1: d = `ADCS_DIV_8;
      3'h5: d = `ADCS_DIV_16;
      3'h2: d = `ADCS_DIV_32;
      3'h6: d = `ADCS_DIV_64;
      default: d = 7'(RC_DIV); // x11: private rc clock
    endcase
    return d;
  endfunction

  logic [6:0] cnt_q;
  logic [6:0] div;
  assign div = div_of(i_sel); // RQ8
  assign o_tick = (cnt_q == div - 7'h01) && !i_restart;

  // free-running divider, restarted at conversion start
  always_ff @(posedge i_clk) begin
    if (i_srst || i_restart || o_tick) begin
      cnt_q <= 7'h00; // RQ19
    end else if (cnt_q < div - 7'h01) begin
      cnt_q <= cnt_q + 7'h01;
    end else begin
      cnt_q <= 7'h00;
    end
  end

  property p_div2;
    @(posedge i_clk) disable iff (i_srst)
      (o_tick && i_sel == 3'h0) ##1 (!i_restart && i_sel == 3'h0)
      |=> (o_tick || i_restart);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 broken"); // RQ8

  property p_restart;
    @(posedge i_clk) disable iff (i_srst)
      i_restart && i_sel == 3'h4 ##1 !i_restart && i_sel == 3'h4
      |-> !o_tick [*3] ##1 o_tick;
  endproperty
  a_restart: assert property (p_restart) else $error("restart misaligned"); // RQ19
endmodule // adcs_tad_gen
`default_nettype wire

/* sim/adcs_afe_model.sv */
// analog front end model: sample-and-hold capacitor plus comparator
`timescale 1ns/1ps
`default_nettype none
module adcs_afe_model (
  input wire logic i_clk,
  input wire logic i_sample,
  input wire logic [9:0] i_level,
  input wire logic [9:0] i_sar_code,
  output logic o_cmp_hi
);
  logic [9:0] held_q;
  // hold cap follows the pin level only while it is connected
  always_ff @(posedge i_clk) begin
    if (i_sample) begin
      held_q <= i_level;
    end
  end
  // comparator: high once the held level reaches the trial code
  assign o_cmp_hi = (held_q >= i_sar_code);
endmodule // adcs_afe_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"
module tb_top;
  localparam int RC = 2;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, cmp_hi;
  logic sample, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pin_level, am;
  logic [3:0] chan_sel;
  logic [9:0] sar_code, level, lv;
  logic [1:0] vref_cfg;
  int mismatches, n_tests, run, low_len, cnt;
  int divs [8] = '{2, 4, 8, 16, 32, 64, RC, RC};
  logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  logic [7:0] offs [5] = '{`ADCS_OFF_CTRL, `ADCS_OFF_PCFG, `ADCS_OFF_CLKF,
    `ADCS_OFF_STAT, `ADCS_OFF_MASK};
  adcs_sequencer #(.RC_DIV(RC), .CHANNELS(16)) i_dut (
    .i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pin_level(pin_level), .i_cmp_hi(cmp_hi), .o_chan_sel(chan_sel),
    .o_sample(sample), .o_sar_code(sar_code), .o_vref_cfg(vref_cfg),
    .o_irq(irq));
  adcs_afe_model i_afe (.i_clk(clk), .i_sample(sample), .i_level(level),
    .i_sar_code(sar_code), .o_cmp_hi(cmp_hi));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // length of the last stretch with the hold cap disconnected
  always @(posedge clk) begin
    if (sample === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        low_len <= run;
      end
      run <= 0;
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; entered just after an edge, leaves just after one
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_sample(output int n);
    n = 0;
    while (sample !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  // one full conversion in clock mode i, checked end to end
  task automatic conv(input int i);
    logic [3:0] ch;
    int n;
    ch = 4'(2 * i + 1);
    lv = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'(10'h2a5 + 61 * i);
    level <= lv;
    apb(1'b1, `ADCS_OFF_PCFG, (i == 3) ? 32'h0f : 32'h00);
    apb(1'b1, `ADCS_OFF_CLKF, {24'h0, i < 7, 4'h0, codes[i]});
    apb(1'b0, `ADCS_OFF_STAT, 32'h0);
    apb(1'b1, `ADCS_OFF_MASK, (i == 2) ? 32'h0 : 32'h1);
    apb(1'b1, `ADCS_OFF_CTRL, {26'h0, ch, 2'b01});
    repeat (8) @(posedge clk);
    apb(1'b1, `ADCS_OFF_CTRL, {26'h0, ch, 2'b11});
    n = 0;
    do begin
      apb(1'b0, `ADCS_OFF_CTRL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 400);
    chk(rd, {26'h0, ch, 2'b01});
    chk(32'(chan_sel), 32'(ch));
    chk(32'(irq), 32'(i != 2));
    rdc(`ADCS_OFF_STAT, 32'h1);
    rdc(`ADCS_OFF_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    rdc(`ADCS_OFF_RESH, (i < 7) ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]});
    rdc(`ADCS_OFF_RESL, (i < 7) ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0});
    wait_sample(n);
    @(posedge clk);
    chk(32'(low_len >= 14 * divs[i] - 1 && low_len <= 14 * divs[i] + 2), 1);
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_level = 16'h0;
    level = 10'h0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      rdc(offs[k], 32'h0);
    end
    chk(32'(sar_code), 32'h200);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `ADCS_OFF_CTRL, 32'h3);
    rdc(`ADCS_OFF_CTRL, 32'h1);
    // port reads with every port configuration code
    pin_level <= 16'ha5c3;
    for (int k = 0; k < 16; k++) begin
      am = (k == 0) ? 16'hffff : (k == 15) ? 16'h0 : 16'((1 << (15 - k)) - 1);
      apb(1'b1, `ADCS_OFF_PCFG, {26'h0, 2'b10, 4'(k)});
      rdc(`ADCS_OFF_PORT, {16'h0, 16'ha5c3 & ~am});
    end
    chk(32'(vref_cfg), 32'h2);
    for (int i = 0; i < 8; i++) begin
      conv(i);
    end
    // abort after software has written the result pair
    apb(1'b1, `ADCS_OFF_RESH, 32'h5a);
    apb(1'b1, `ADCS_OFF_RESL, 32'h3c);
    apb(1'b1, `ADCS_OFF_CLKF, 32'h86);
    apb(1'b1, `ADCS_OFF_CTRL, 32'h09);
    repeat (8) @(posedge clk);
    apb(1'b1, `ADCS_OFF_CTRL, 32'h0b);
    repeat (100) @(posedge clk);
    apb(1'b1, `ADCS_OFF_CTRL, 32'h09);
    wait_sample(cnt);
    chk(32'(cnt >= 62 && cnt <= 130), 32'h1);
    rdc(`ADCS_OFF_STAT, 32'h2);
    rdc(`ADCS_OFF_RESH, 32'h5a);
    rdc(`ADCS_OFF_RESL, 32'h3c);
    rdc(`ADCS_OFF_CTRL, 32'h09);
    // reset in mid conversion
    apb(1'b1, `ADCS_OFF_CTRL, 32'h0b);
    repeat (40) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(32'(sample), 32'h0);
    rdc(`ADCS_OFF_CTRL, 32'h0);
    rdc(`ADCS_OFF_STAT, 32'h0);
    chk(32'(sar_code), 32'h200);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
